// ---- rtl/cmbs_store.sv ----
// can message buffer store: avalon slave, three transmit buffers, receive fifo, stamps
//
// Functional notes
// - stamp active buffer after valid frame end
// - stamp from free-running bit counter, no overflow flag
// - stamp counter held zero in init mode
// - stamp bytes read-only, writes ignored
// - three independent transmit buffers
// - transmit buffer: 13 bytes, priority, two stamps
// - sent buffer sets empty flag, interrupt if enabled
// - each arbitration picks lowest local priority
// - equal priority: lower buffer index wins
// - granted abort sets acknowledge, empty, interrupt
// - acknowledge reads one aborted, zero sent
// - five-stage receive fifo, foreground visible
// - receive buffer holds 15 bytes incl. stamp
// - accepted message enters fifo, sets full flag
// - bad or filtered message never enters fifo
// - own frames outside loopback stay in background
// - loopback treats own frames as incoming
// - lost arbitration: winning frame received normally
// - full fifo drops message, overrun interrupt
// - transmit continues; accept again when stage frees
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "cmbs_defines.svh"
module cmbs_store (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic [9:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output wire logic [31:0] avs_readdata,
   output wire logic        avs_waitrequest,
   input  wire logic        eng_bit_tick,
   input  wire logic        eng_tx_start,
   input  wire logic        eng_tx_done,
   input  wire logic        eng_tx_ok,
   input  wire logic [3:0]  eng_tx_rd_addr,
   output wire logic [7:0]  eng_tx_rd_data,
   output wire logic        eng_tx_req,
   output wire logic [1:0]  eng_tx_idx,
   input  wire logic        eng_rx_we,
   input  wire logic [3:0]  eng_rx_addr,
   input  wire logic [7:0]  eng_rx_data,
   input  wire logic        eng_rx_eof,
   input  wire logic        eng_rx_valid,
   input  wire logic        eng_rx_accept,
   input  wire logic        eng_rx_own,
   output wire logic        init_mode,
   output wire logic        tx_irq,
   output wire logic        rx_irq,
   output wire logic        err_irq
);
   cmbs_link_if lk ();

   cmbs_pkg::cmbs_bus_e                     st_q;
   logic                                    waitreq_q;
   logic [31:0]                             rdata_q;
   cmbs_pkg::cmbs_byte_t                    ctrl_q;
   cmbs_pkg::cmbs_byte_t                    ien_q;
   cmbs_pkg::cmbs_byte_t                    rd_val;
   cmbs_pkg::cmbs_byte_t                    wdat;
   cmbs_pkg::cmbs_byte_t                    eng_rd_q;
   cmbs_pkg::cmbs_msg_t [`CMBS_NTX-1:0]     txbuf_q;
   logic [2:0]                              txe_q;
   logic [2:0]                              txe_d;
   logic [2:0]                              sel_q;
   logic [2:0]                              arq_q;
   logic [2:0]                              aak_q;
   logic [2:0]                              abort_go;
   logic [2:0]                              done_set;
   logic [2:0]                              busy;
   logic [2:0]                              cpu_clr;
   logic [1:0]                              act_q;
   logic [1:0]                              sel_idx;
   logic                                    act_vld_q;
   logic                                    ovr_q;
   logic                                    sel_ok;
   logic                                    wr_fire;
   logic                                    tx_ok_done;
   logic                                    rx_keep;
   logic                                    w_ctrl;
   logic                                    w_tflg;
   logic                                    w_tsel;
   logic                                    w_tarq;
   logic                                    w_rflg;
   logic                                    w_ien;
   logic [15:0]                             stamp_q;
   logic [3:0]                              rg;
   logic [3:0]                              by;
   logic                                    tx_irq_q;
   logic                                    rx_irq_q;
   logic                                    err_irq_q;

   function automatic logic [2:0] cmbs_dec(input logic [1:0] i);
      return 3'h1 << i;
   endfunction

   function automatic logic [1:0] cmbs_oh2i(input logic [2:0] oh);
      logic [1:0] r;
      r = 2'h0;
      for (int i = `CMBS_NTX - 1; i >= 0; i--) begin
         if (oh[i]) begin
            r = 2'(i);
         end
      end
      return r;
   endfunction

   function automatic logic cmbs_hit(input logic f, input logic [3:0] r,
                                     input logic [3:0] b, input logic [3:0] ix);
      return f && r == `CMBS_RG_CTL && b == ix;
   endfunction

   cmbs_tx_sched u_sched (
      .clk  (clk),
      .rstn (rstn),
      .lk   (lk.sched)
   );

   cmbs_rx_fifo u_fifo (
      .clk  (clk),
      .rstn (rstn),
      .lk   (lk.fifo)
   );

   // bus decode; a write lands on the edge that ends the ack cycle
   assign rg      = avs_address[`CMBS_AD_RG_HI:`CMBS_AD_RG_LO];
   assign by      = avs_address[`CMBS_AD_BY_HI:`CMBS_AD_BY_LO];
   assign wdat    = avs_writedata[7:0];
   assign wr_fire = st_q == cmbs_pkg::st_ack && avs_write && avs_byteenable[0];
   assign w_ctrl  = cmbs_hit(wr_fire, rg, by, `CMBS_IX_CTRL);
   assign w_tflg  = cmbs_hit(wr_fire, rg, by, `CMBS_IX_TFLG);
   assign w_tsel  = cmbs_hit(wr_fire, rg, by, `CMBS_IX_TSEL);
   assign w_tarq  = cmbs_hit(wr_fire, rg, by, `CMBS_IX_TARQ);
   assign w_rflg  = cmbs_hit(wr_fire, rg, by, `CMBS_IX_RFLG);
   assign w_ien   = cmbs_hit(wr_fire, rg, by, `CMBS_IX_IEN);
   assign sel_idx = cmbs_oh2i(sel_q);
   // window only open while the selected buffer is released
   assign sel_ok  = |(sel_q & txe_q);

   // transmit flag bookkeeping
   assign tx_ok_done = eng_tx_done && eng_tx_ok && act_vld_q;
   assign done_set   = tx_ok_done ? cmbs_dec(act_q) : 3'h0;
   // a frame already on the wire cannot be aborted
   assign busy       = act_vld_q ? cmbs_dec(act_q) : 3'h0;
   assign abort_go   = arq_q & ~txe_q & ~busy;
   assign cpu_clr    = w_tflg ? (wdat[2:0] & txe_q) : 3'h0;
   // hardware set wins over a same-cycle software clear
   assign txe_d      = (txe_q & ~cpu_clr) | done_set | abort_go;

   // receive qualification
   assign rx_keep = eng_rx_eof && eng_rx_valid && eng_rx_accept &&
                    (!eng_rx_own || ctrl_q[`CMBS_CTL_LOOP]);

   always_comb begin
      for (int i = 0; i < `CMBS_NTX; i++) begin
         lk.tx_local_priority[i] = txbuf_q[i][`CMBS_BY_LOCAL_PRIORITY];
      end
   end
   assign lk.tx_pend  = ~txe_q;
   assign lk.bg_we    = eng_rx_we;
   assign lk.bg_addr  = eng_rx_addr;
   assign lk.bg_data  = eng_rx_data;
   assign lk.push     = rx_keep;
   assign lk.pop      = w_rflg && wdat[`CMBS_RF_RXF] && !lk.empty;
   assign lk.stamp    = stamp_q;
   assign lk.stamp_en = ctrl_q[`CMBS_CTL_TIME];

   // read mux
   always_comb begin
      rd_val = 8'h00;
      if (rg == `CMBS_RG_TXWIN) begin
         if (sel_ok) begin
            rd_val = txbuf_q[sel_idx][by];
         end
      end else if (rg == `CMBS_RG_RXWIN) begin
         if (!lk.empty) begin
            rd_val = lk.head[by];
         end
      end else if (rg == `CMBS_RG_CTL) begin
         case (by)
            `CMBS_IX_CTRL: rd_val = ctrl_q;
            `CMBS_IX_TFLG: rd_val = {5'h00, txe_q};
            `CMBS_IX_TSEL: rd_val = {5'h00, sel_q};
            `CMBS_IX_TARQ: rd_val = {5'h00, arq_q};
            `CMBS_IX_TAAK: rd_val = {5'h00, aak_q};
            `CMBS_IX_RFLG: begin
               rd_val[`CMBS_RF_RXF] = !lk.empty;
               rd_val[`CMBS_RF_OVR] = ovr_q;
            end
            `CMBS_IX_IEN:  rd_val = ien_q;
            default:       rd_val = 8'h00;
         endcase
      end
   end

   // avalon handshake: one wait cycle, then ack
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_q      <= cmbs_pkg::st_idle;
         waitreq_q <= 1'b1;
         rdata_q   <= 32'h0000_0000;
      end else begin
         unique case (st_q)
            cmbs_pkg::st_idle: begin
               if (avs_read || avs_write) begin
                  st_q      <= cmbs_pkg::st_ack;
                  waitreq_q <= 1'b0;
                  rdata_q   <= {24'h00_0000, rd_val};
               end
            end
            cmbs_pkg::st_ack: begin
               st_q      <= cmbs_pkg::st_idle;
               waitreq_q <= 1'b1;
            end
         endcase
      end
   end

   // control and interrupt enables
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_q <= `CMBS_CTL_RST;
         ien_q  <= 8'h00;
      end else begin
         if (w_ctrl) begin
            ctrl_q <= wdat;
         end
         if (w_ien) begin
            ien_q <= wdat;
         end
      end
   end

   // stamp counter wraps silently, no overflow flag by design
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         stamp_q <= 16'h0000;
      end else if (ctrl_q[`CMBS_CTL_INIT]) begin
         stamp_q <= 16'h0000;
      end else if (eng_bit_tick) begin
         stamp_q <= stamp_q + 16'h0001;
      end
   end

   // transmit flags, selection, abort
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         txe_q <= `CMBS_TXE_RST;
         sel_q <= 3'h0;
         arq_q <= 3'h0;
         aak_q <= 3'h0;
      end else begin
         txe_q <= txe_d;
         if (w_tsel) begin
            sel_q <= (wdat[2:0] & txe_q) & (~(wdat[2:0] & txe_q) + 3'h1);
         end
         arq_q <= (arq_q | (w_tarq ? (wdat[2:0] & ~txe_q) : 3'h0)) & ~txe_d;
         aak_q <= (aak_q & ~done_set & ~cpu_clr) | abort_go;
      end
   end

   // active transmission, re-chosen at every arbitration start
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         act_q     <= 2'h0;
         act_vld_q <= 1'b0;
      end else if (eng_tx_start) begin
         act_q     <= lk.tx_pick_idx;
         act_vld_q <= lk.tx_pick_vld;
      end else if (eng_tx_done) begin
         act_vld_q <= 1'b0;
      end
   end

   // transmit buffer storage; stamp bytes only hardware-written
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         txbuf_q <= '0;
      end else begin
         if (wr_fire && rg == `CMBS_RG_TXWIN && sel_ok && by < `CMBS_BY_STH) begin
            txbuf_q[sel_idx][by] <= wdat;
         end
         if (tx_ok_done && ctrl_q[`CMBS_CTL_TIME]) begin
            txbuf_q[act_q][`CMBS_BY_STH] <= stamp_q[15:8];
            txbuf_q[act_q][`CMBS_BY_STL] <= stamp_q[7:0];
         end
      end
   end

   // overrun flag, write one to clear, set wins
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ovr_q <= 1'b0;
      end else begin
         ovr_q <= (ovr_q & ~(w_rflg && wdat[`CMBS_RF_OVR])) |
                  (rx_keep && lk.full && !lk.pop);
      end
   end

   // registered outputs
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         eng_rd_q  <= 8'h00;
         tx_irq_q  <= 1'b0;
         rx_irq_q  <= 1'b0;
         err_irq_q <= 1'b0;
      end else begin
         eng_rd_q  <= txbuf_q[act_q][eng_tx_rd_addr];
         tx_irq_q  <= |(txe_q & ien_q[2:0]);
         rx_irq_q  <= !lk.empty && ien_q[`CMBS_IEN_RX];
         err_irq_q <= ovr_q && ien_q[`CMBS_IEN_OVR];
      end
   end

   assign avs_readdata    = rdata_q;
   assign avs_waitrequest = waitreq_q;
   assign eng_tx_rd_data  = eng_rd_q;
   assign eng_tx_req      = lk.tx_pick_vld;
   assign eng_tx_idx      = lk.tx_pick_idx;
   assign init_mode       = ctrl_q[`CMBS_CTL_INIT];
   assign tx_irq          = tx_irq_q;
   assign rx_irq          = rx_irq_q;
   assign err_irq         = err_irq_q;

   a_stamp_init: assert property (@(posedge clk) disable iff (!rstn)
      ctrl_q[`CMBS_CTL_INIT] |=> stamp_q == 16'h0000)
      else $error("stamp counter not cleared in init");
   a_stamp_wrap: assert property (@(posedge clk) disable iff (!rstn)
      (stamp_q == 16'hFFFF && eng_bit_tick && !ctrl_q[`CMBS_CTL_INIT])
      |=> stamp_q == 16'h0000)
      else $error("stamp counter did not wrap");
   a_stamp_ro: assert property (@(posedge clk) disable iff (!rstn)
      (wr_fire && rg == `CMBS_RG_TXWIN && by >= `CMBS_BY_STH && !eng_tx_done)
      |=> $stable(txbuf_q))
      else $error("stamp byte took a bus write");
   a_stamp_take: assert property (@(posedge clk) disable iff (!rstn)
      (tx_ok_done && ctrl_q[`CMBS_CTL_TIME])
      |=> {txbuf_q[$past(act_q)][`CMBS_BY_STH], txbuf_q[$past(act_q)][`CMBS_BY_STL]}
          == $past(stamp_q))
      else $error("transmit stamp not stored");
   a_tx_release: assert property (@(posedge clk) disable iff (!rstn)
      tx_ok_done |=> txe_q[$past(act_q)] && !aak_q[$past(act_q)])
      else $error("sent buffer not released as sent");
   a_tx_irq: assert property (@(posedge clk) disable iff (!rstn)
      (tx_ok_done && ien_q[act_q] && !w_ien) |-> ##2 tx_irq_q)
      else $error("transmit interrupt missing");
   a_abort_grant: assert property (@(posedge clk) disable iff (!rstn)
      (arq_q[0] && !txe_q[0] && !busy[0]) |=> txe_q[0] && aak_q[0] && !arq_q[0])
      else $error("abort not granted");
   a_own_hold: assert property (@(posedge clk) disable iff (!rstn)
      (eng_rx_eof && eng_rx_own && !ctrl_q[`CMBS_CTL_LOOP]) |-> !lk.push)
      else $error("own frame queued outside loopback");
   a_rx_enter: assert property (@(posedge clk) disable iff (!rstn)
      (rx_keep && !lk.full) |=> !lk.empty)
      else $error("accepted message not queued");
   a_ovr_flag: assert property (@(posedge clk) disable iff (!rstn)
      (rx_keep && lk.full && !lk.pop) |=> ovr_q)
      else $error("overrun not flagged");
endmodule

// ---- rtl/cmbs_defines.svh ----
// register map, field positions, reset values and sizes of the message buffer store
`ifndef CMBS_DEFINES_SVH
`define CMBS_DEFINES_SVH
`define CMBS_NTX      3
`define CMBS_NRX      3'h5
`define CMBS_RX_LAST  3'h4
`define CMBS_RG_TXWIN 4'h0
`define CMBS_RG_RXWIN 4'h1
`define CMBS_RG_CTL   4'h2
`define CMBS_IX_CTRL  4'h0
`define CMBS_IX_TFLG  4'h1
`define CMBS_IX_TSEL  4'h2
`define CMBS_IX_TARQ  4'h3
`define CMBS_IX_TAAK  4'h4
`define CMBS_IX_RFLG  4'h5
`define CMBS_IX_IEN   4'h6
`define CMBS_BY_LOCAL_PRIORITY  4'hD
`define CMBS_BY_STH   4'hE
`define CMBS_BY_STL   4'hF
`define CMBS_CTL_INIT 0
`define CMBS_CTL_LOOP 1
`define CMBS_CTL_TIME 2
`define CMBS_CTL_RST  8'h01
`define CMBS_IEN_RX   3
`define CMBS_IEN_OVR  4
`define CMBS_RF_RXF   0
`define CMBS_RF_OVR   1
`define CMBS_TXE_RST  3'h7
`define CMBS_AD_RG_HI 9
`define CMBS_AD_RG_LO 6
`define CMBS_AD_BY_HI 5
`define CMBS_AD_BY_LO 2
`endif

// ---- rtl/cmbs_pkg.sv ----
// shared types of the message buffer store
package cmbs_pkg;
   typedef logic [7:0] cmbs_byte_t;
   typedef cmbs_byte_t [15:0] cmbs_msg_t;
   typedef enum logic [0:0] {
      st_idle = 1'b0,
      st_ack  = 1'b1
   } cmbs_bus_e;
endpackage

// ---- rtl/cmbs_link_if.sv ----
// links between the store top, the transmit scheduler and the receive fifo
`timescale 1ns/1ps
interface cmbs_link_if;
   logic [2:0]                   tx_pend;
   cmbs_pkg::cmbs_byte_t [2:0]   tx_local_priority;
   logic                         tx_pick_vld;
   logic [1:0]                   tx_pick_idx;
   logic                         bg_we;
   logic [3:0]                   bg_addr;
   cmbs_pkg::cmbs_byte_t         bg_data;
   logic                         push;
   logic                         pop;
   logic [15:0]                  stamp;
   logic                         stamp_en;
   logic                         full;
   logic                         empty;
   cmbs_pkg::cmbs_msg_t          head;
   modport top (output tx_pend, tx_local_priority, bg_we, bg_addr, bg_data, push, pop, stamp,
                stamp_en, input tx_pick_vld, tx_pick_idx, full, empty, head);
   modport sched (input tx_pend, tx_local_priority, output tx_pick_vld, tx_pick_idx);
   modport fifo (input bg_we, bg_addr, bg_data, push, pop, stamp, stamp_en,
                 output full, empty, head);
endinterface

// ---- rtl/cmbs_tx_sched.sv ----
// local-priority pick among pending transmit buffers
`timescale 1ns/1ps
`include "cmbs_defines.svh"
module cmbs_tx_sched (
   input wire logic   clk,
   input wire logic   rstn,
   cmbs_link_if.sched lk
);
   logic [2:0]                 pend_h;
   cmbs_pkg::cmbs_byte_t [2:0] local_priority_h;

   // descending scan with <= lets the lower index win a tie
   function automatic logic [2:0] cmbs_pick(input logic [2:0] pend,
                                            input cmbs_pkg::cmbs_byte_t [2:0] local_priority);
      logic                 found;
      logic [1:0]           idx;
      cmbs_pkg::cmbs_byte_t best;
      found = 1'b0;
      idx = 2'h0;
      best = 8'hFF;
      for (int i = `CMBS_NTX - 1; i >= 0; i--) begin
         if (pend[i] && (!found || local_priority[i] <= best)) begin
            found = 1'b1;
            idx = 2'(i);
            best = local_priority[i];
         end
      end
      return {found, idx};
   endfunction

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         lk.tx_pick_vld <= 1'b0;
         lk.tx_pick_idx <= 2'h0;
      end else begin
         {lk.tx_pick_vld, lk.tx_pick_idx} <= cmbs_pick(lk.tx_pend, lk.tx_local_priority);
      end
   end

   // assertion helpers: inputs seen by the last pick
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pend_h <= 3'h0;
         local_priority_h <= '0;
      end else begin
         pend_h <= lk.tx_pend;
         local_priority_h <= lk.tx_local_priority;
      end
   end

   a_pick_lowest: assert property (@(posedge clk) disable iff (!rstn)
      lk.tx_pick_vld |-> pend_h[lk.tx_pick_idx] &&
      (!pend_h[0] || lk.tx_pick_idx == 2'h0 || local_priority_h[0] > local_priority_h[lk.tx_pick_idx]) &&
      (!pend_h[1] || lk.tx_pick_idx != 2'h2 || local_priority_h[1] > local_priority_h[2]) &&
      (!pend_h[1] || local_priority_h[1] >= local_priority_h[lk.tx_pick_idx]) &&
      (!pend_h[2] || local_priority_h[2] >= local_priority_h[lk.tx_pick_idx]))
      else $error("pick is not the lowest pending priority");
   a_pick_tie: assert property (@(posedge clk) disable iff (!rstn)
      (lk.tx_pick_vld && ((pend_h[0] && pend_h[2] && local_priority_h[0] == local_priority_h[2]) ||
                          (pend_h[1] && pend_h[2] && local_priority_h[1] == local_priority_h[2])))
      |-> lk.tx_pick_idx != 2'h2)
      else $error("tie not resolved to lower index");
endmodule

// ---- rtl/cmbs_rx_fifo.sv ----
// receive background buffer and five-stage message fifo
`timescale 1ns/1ps
`include "cmbs_defines.svh"
module cmbs_rx_fifo (
   input wire logic  clk,
   input wire logic  rstn,
   cmbs_link_if.fifo lk
);
   cmbs_pkg::cmbs_msg_t bg_q;
   cmbs_pkg::cmbs_msg_t mem_q [5];
   cmbs_pkg::cmbs_msg_t ent;
   logic [2:0]          rd_q;
   logic [2:0]          wr_q;
   logic [2:0]          cnt_q;
   logic                push_ok;
   logic                pop_ok;

   function automatic logic [2:0] cmbs_nxt(input logic [2:0] p);
      return (p == `CMBS_RX_LAST) ? 3'h0 : p + 3'h1;
   endfunction

   assign lk.full  = cnt_q == `CMBS_NRX;
   assign lk.empty = cnt_q == 3'h0;
   assign lk.head  = mem_q[rd_q];
   assign pop_ok   = lk.pop && !lk.empty;
   // a stage freed in the same cycle is reused at once
   assign push_ok  = lk.push && (!lk.full || lk.pop);

   always_comb begin
      ent = bg_q;
      ent[`CMBS_BY_LOCAL_PRIORITY] = 8'h00;
      if (lk.stamp_en) begin
         ent[`CMBS_BY_STH] = lk.stamp[15:8];
         ent[`CMBS_BY_STL] = lk.stamp[7:0];
      end
   end

   // rejected frames simply get overwritten here
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bg_q <= '0;
      end else if (lk.bg_we) begin
         bg_q[lk.bg_addr] <= lk.bg_data;
      end
   end

   always_ff @(posedge clk) begin
      if (push_ok) begin
         mem_q[wr_q] <= ent;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rd_q  <= 3'h0;
         wr_q  <= 3'h0;
         cnt_q <= 3'h0;
      end else begin
         if (push_ok) begin
            wr_q <= cmbs_nxt(wr_q);
         end
         if (pop_ok) begin
            rd_q <= cmbs_nxt(rd_q);
         end
         cnt_q <= cnt_q + {2'h0, push_ok} - {2'h0, pop_ok};
      end
   end

   a_fifo_drop: assert property (@(posedge clk) disable iff (!rstn)
      (lk.push && lk.full && !lk.pop) |=> $stable(wr_q) && cnt_q == `CMBS_NRX)
      else $error("message entered a full fifo");
   a_fifo_reuse: assert property (@(posedge clk) disable iff (!rstn)
      (lk.push && lk.full && lk.pop) |=> cnt_q == `CMBS_NRX && wr_q != $past(wr_q))
      else $error("freed stage not reused");
endmodule

// ---- dv/cmbs_eng_model.sv ----
// can engine stand-in: bit ticks, transmit attempts, received frames
`timescale 1ns/1ps
module cmbs_eng_model (
   input  wire logic  clk,
   output logic       eng_bit_tick,
   output logic       eng_tx_start,
   output logic       eng_tx_done,
   output logic       eng_tx_ok,
   output logic       eng_rx_we,
   output logic [3:0] eng_rx_addr,
   output logic [7:0] eng_rx_data,
   output logic       eng_rx_eof,
   output logic       eng_rx_valid,
   output logic       eng_rx_accept,
   output logic       eng_rx_own
);
   initial begin
      {eng_bit_tick, eng_tx_start, eng_tx_done, eng_tx_ok, eng_rx_we} = '0;
      {eng_rx_addr, eng_rx_data, eng_rx_eof, eng_rx_valid, eng_rx_accept, eng_rx_own} = '0;
   end
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge clk) eng_bit_tick <= 1'b1;
         @(posedge clk) eng_bit_tick <= 1'b0;
      end
   endtask
   task automatic xmit(input logic ok);
      @(posedge clk) eng_tx_start <= 1'b1;
      @(posedge clk) eng_tx_start <= 1'b0;
      repeat (4) @(posedge clk);
      eng_tx_done <= 1'b1;
      eng_tx_ok <= ok;
      @(posedge clk) eng_tx_done <= 1'b0;
      eng_tx_ok <= ~ok;
   endtask
   // released lines flip so stale values never look valid
   task automatic frame(input logic v, a, o, input logic [7:0] b);
      for (int i = 0; i < 13; i++) begin
         @(posedge clk) eng_rx_we <= 1'b1;
         eng_rx_addr <= 4'(i);
         eng_rx_data <= b + 8'(i);
      end
      @(posedge clk) eng_rx_we <= 1'b0;
      eng_rx_data <= ~eng_rx_data;
      {eng_rx_eof, eng_rx_valid, eng_rx_accept, eng_rx_own} <= {1'b1, v, a, o};
      @(posedge clk) eng_rx_eof <= 1'b0;
      {eng_rx_valid, eng_rx_accept, eng_rx_own} <= ~{v, a, o};
      repeat (2) @(posedge clk);
   endtask
endmodule

// ---- dv/tb.sv ----
// bench: avalon register access plus engine stand-in
`timescale 1ns/1ps
module tb;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic [9:0]  avs_address = '0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = '0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        eng_bit_tick, eng_tx_start, eng_tx_done, eng_tx_ok, eng_rx_we, eng_rx_eof;
   logic        eng_rx_valid, eng_rx_accept, eng_rx_own, eng_tx_req, init_mode;
   logic        tx_irq, rx_irq, err_irq;
   logic [3:0]  eng_rx_addr;
   logic [7:0]  eng_rx_data, r;
   logic [3:0]  be = 4'hF;
   logic [3:0]  tx_rd_addr = 4'hD;
   logic [7:0]  tx_rd_data;
   logic [1:0]  eng_tx_idx;
   int          bad_count = 0;
   int          num_checks = 0;
   always #2.5 clk = ~clk;
   cmbs_store dut (.clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable(be), .avs_readdata, .avs_waitrequest, .eng_bit_tick, .eng_tx_start,
      .eng_tx_done, .eng_tx_ok, .eng_tx_rd_addr(tx_rd_addr), .eng_tx_rd_data(tx_rd_data),
      .eng_tx_req, .eng_tx_idx, .eng_rx_we, .eng_rx_addr, .eng_rx_data, .eng_rx_eof,
      .eng_rx_valid, .eng_rx_accept, .eng_rx_own, .init_mode, .tx_irq, .rx_irq, .err_irq);
   cmbs_eng_model eng (.clk, .eng_bit_tick, .eng_tx_start, .eng_tx_done, .eng_tx_ok,
      .eng_rx_we, .eng_rx_addr, .eng_rx_data, .eng_rx_eof, .eng_rx_valid, .eng_rx_accept,
      .eng_rx_own);
   task automatic finish_test;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] g, e);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // bounded wait: a hung slave ends the run
   task automatic acc(input logic w, input logic [9:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_write <= w;
      avs_read <= ~w;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 64);
      r = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 64) begin
         bad_count++;
         finish_test();
      end
   endtask
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      acc(1'b1, a, d);
   endtask
   task automatic rc(input logic [9:0] a, input logic [7:0] e, input string nm);
      acc(1'b0, a, 8'h00);
      chk(nm, r, e);
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      rc(10'h080, 8'h01, "ctrl");
      chk("init_mode", {7'h0, init_mode}, 8'h01);
      rc(10'h084, 8'h07, "tx_flag_reg");
      rc(10'h3FC, 8'h00, "unmapped");
      for (int i = 0; i < 3; i++) begin
         wr(10'h088, 8'h01 << i);
         rc(10'h088, 8'h01 << i, "tx_buffer_select");
         wr(10'h034, (i == 0) ? 8'h05 : 8'h03);
      end
      wr(10'h098, 8'h1A);
      be <= 4'h0;
      wr(10'h098, 8'h00);
      be <= 4'hF;
      rc(10'h098, 8'h1A, "irq_enable");
      wr(10'h080, 8'h04);
      wr(10'h084, 8'h07);
      chk("init_mode", {7'h0, init_mode}, 8'h00);
      repeat (3) @(posedge clk);
      chk("eng_tx_idx", {eng_tx_req, 5'h0, eng_tx_idx}, 8'h81);
      chk("tx_irq", {7'h0, tx_irq}, 8'h00);
      chk("eng_tx_rd_data", tx_rd_data, 8'h05);
      eng.ticks(10);
      eng.xmit(1'b1);
      tx_rd_addr <= 4'hF;
      rc(10'h084, 8'h02, "tx_flag_reg");
      chk("tx_irq", {7'h0, tx_irq}, 8'h01);
      rc(10'h090, 8'h00, "abort_ack_reg");
      chk("eng_tx_rd_data", tx_rd_data, 8'h0A);
      wr(10'h088, 8'h02);
      rc(10'h038, 8'h00, "stamp_high_byte");
      rc(10'h03C, 8'h0A, "stamp_low_byte");
      wr(10'h03C, 8'hFF);
      rc(10'h03C, 8'h0A, "stamp_low_byte");
      wr(10'h08C, 8'h01);
      rc(10'h084, 8'h03, "tx_flag_reg");
      rc(10'h090, 8'h01, "abort_ack_reg");
      chk("eng_tx_idx", {eng_tx_req, 5'h0, eng_tx_idx}, 8'h82);
      eng.xmit(1'b0);
      rc(10'h084, 8'h03, "tx_flag_reg");
      eng.frame(1'b1, 1'b1, 1'b0, 8'h40);
      rc(10'h094, 8'h01, "rx_flag_reg");
      chk("rx_irq", {7'h0, rx_irq}, 8'h01);
      rc(10'h040, 8'h40, "rx_foreground_buffer");
      rc(10'h07C, 8'h0A, "stamp_low_byte");
      wr(10'h078, 8'hFF);
      rc(10'h078, 8'h00, "stamp_high_byte");
      eng.frame(1'b0, 1'b1, 1'b0, 8'h00);
      eng.frame(1'b1, 1'b0, 1'b0, 8'h00);
      eng.frame(1'b1, 1'b1, 1'b1, 8'h00);
      wr(10'h094, 8'h01);
      rc(10'h094, 8'h00, "rx_flag_reg");
      for (int i = 1; i < 7; i++) eng.frame(1'b1, 1'b1, 1'b0, 8'(i * 16));
      rc(10'h094, 8'h03, "rx_flag_reg");
      chk("err_irq", {7'h0, err_irq}, 8'h01);
      wr(10'h094, 8'h01);
      eng.frame(1'b1, 1'b1, 1'b0, 8'hA0);
      for (int i = 2; i < 7; i++) begin
         rc(10'h040, (i == 6) ? 8'hA0 : 8'(i * 16), "rx_foreground_buffer");
         wr(10'h094, 8'h01);
      end
      wr(10'h080, 8'h06);
      eng.frame(1'b1, 1'b1, 1'b1, 8'hC0);
      rc(10'h040, 8'hC0, "rx_foreground_buffer");
      finish_test();
   end
endmodule
